// ===== verilog/fbsel_pkg.sv
// Purpose: constants and carrier types for the feedback source selector
// Assumes: two feedback sensors, sensorless at slot 1 and internal encoder at slot 2
// Notes: object indices and subindices are the dictionary addresses of the registers
package fbsel_pkg;

   localparam int unsigned NUM_SENSORS = 2;

   // object dictionary addresses
   localparam logic [15:0] IDX_SELECT = 16'h3203;
   localparam logic [15:0] IDX_MAP = 16'h3204;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_SENSORLESS = 8'h01;
   localparam logic [7:0] SUB_ENCODER = 8'h02;

   // values after reset and fixed table contents
   localparam logic [7:0] SELECT_COUNT_RESET = 8'h02;
   localparam logic [7:0] MAP_COUNT_RESET = 8'h02;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [15:0] CFG_INDEX_SENSORLESS = 16'h3380;
   localparam logic [15:0] CFG_INDEX_ENCODER = 16'h33A0;

   // role bit positions inside each mask
   localparam int unsigned BIT_POS = 0;
   localparam int unsigned BIT_VEL = 1;
   localparam int unsigned BIT_COMM = 2;

   // sensor numbers as reported on the source outputs
   localparam logic [1:0] SENSOR_NONE = 2'h0;
   localparam logic [1:0] SENSOR_SENSORLESS = 2'h1;
   localparam logic [1:0] SENSOR_ENCODER = 2'h2;

   // entry [0] is sensor 1, entry [1] is sensor 2
   typedef logic [NUM_SENSORS-1:0][7:0] mask_set_type;

   typedef struct packed {
      logic valid;
      logic fallback;
      logic [1:0] sensor;
   } role_sel_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] index;
      logic [7:0] sub;
      logic [15:0] wdata;
   } od_req_type;

   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] rdata;
   } od_rsp_type;

   typedef enum logic [1:0] {
      ST_HALT = 2'b01,
      ST_RUN = 2'b10
   } phase_type;

   typedef struct packed {
      phase_type phase;
      mask_set_type obj_mask;
      mask_set_type act_mask;
      logic act_cl;
      role_sel_type pos;
      role_sel_type vel;
      role_sel_type comm;
      logic missing;
      od_rsp_type rsp;
   } state_type;

endpackage

// ===== verilog/fbsel_resolver.sv
// Purpose: resolve active role masks into one sensor per controller role
// Assumes: masks already latched; purely combinational
// Notes: sensor 1 is only a fallback when nothing from sensor 2 upward is set
`timescale 1ns/1ps
module fbsel_resolver (
   input wire fbsel_pkg::mask_set_type masks_in,
   input wire logic closed_loop_in,
   output fbsel_pkg::role_sel_type pos_out,
   output fbsel_pkg::role_sel_type vel_out,
   output fbsel_pkg::role_sel_type comm_out
);
   import fbsel_pkg::*;

   // search from sensor 2 upward, first hit wins, else fall back to sensorless
   function automatic role_sel_type pick(input mask_set_type m, input int unsigned b);
      role_sel_type r;
      logic found;
      r.valid = 1'b0;
      r.fallback = 1'b1;
      r.sensor = SENSOR_NONE;
      found = 1'b0;
      for (int unsigned s = 1; s < NUM_SENSORS; s++) begin
         if (!found && m[s][b]) begin
            found = 1'b1;
            r.valid = 1'b1;
            r.fallback = 1'b0;
            r.sensor = 2'(s + 1);
         end
      end
      if (!found && m[0][b]) begin
         r.valid = 1'b1;
         r.sensor = SENSOR_SENSORLESS;
      end
      return r;
   endfunction

   always_comb begin
      pos_out = pick(masks_in, BIT_POS);
      vel_out = pick(masks_in, BIT_VEL);
      if (closed_loop_in) begin
         comm_out = pick(masks_in, BIT_COMM);
      end else begin
         // open loop: commutation bit carries no meaning, not flagged either
         comm_out = '0;
      end
   end

endmodule // fbsel_resolver

// ===== verilog/feedback_source_select.sv
// Purpose: feedback sensor role selection with object dictionary access
// Assumes: RUN_IN and CLOSED_LOOP_SELECT_IN come from drive logic on CLK_IN
// Notes: role outputs change one cycle after the masks are latched on run entry
//
// How it works
// - masks written while running are held and applied on next run entry
// - running assignment stays unchanged by writes until run is entered again
// - selection entry count reads 02, the number of existing sensors
// - mask bit 0 position, bit 1 velocity, bit 2 commutation; others unused
// - slot 1 is sensorless, slot 2 internal encoder; both masks reset 00
// - per role, search sensors from sensor 2 upward through existing ones
// - first sensor with the role bit set is taken and search stops
// - with closed loop select clear at run entry, commutation bits are ignored
// - in open loop, velocity and position bits still pick display sources
// - read-only mapping table with count entry gives config index per sensor
// - mapping entries read 3380 for sensorless and 33A0 for encoder
`timescale 1ns/1ps
module feedback_source_select (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic RUN_IN,
   input wire logic CLOSED_LOOP_SELECT_IN,
   input wire fbsel_pkg::od_req_type OD_REQ_IN,
   output fbsel_pkg::od_rsp_type OD_RSP_OUT,
   output logic [1:0] POS_SRC_OUT,
   output logic POS_VALID_OUT,
   output logic [1:0] VEL_SRC_OUT,
   output logic VEL_VALID_OUT,
   output logic [1:0] COMM_SRC_OUT,
   output logic COMM_VALID_OUT,
   output logic MISSING_OUT
);
   import fbsel_pkg::*;

   state_type q;
   state_type d;
   role_sel_type res_pos;
   role_sel_type res_vel;
   role_sel_type res_comm;

   // resolver sees only the latched copy, so bus writes never glitch the roles
   fbsel_resolver resolver (
      .masks_in(q.act_mask),
      .closed_loop_in(q.act_cl),
      .pos_out(res_pos),
      .vel_out(res_vel),
      .comm_out(res_comm)
   );

   always_comb begin
      d = q;
      d.rsp = '0;

      // the active copy only moves on entry to the running phase
      case (q.phase)
         ST_HALT: begin
            if (RUN_IN) begin
               d.phase = ST_RUN;
               // a write in the entry cycle misses this copy; settle masks first
               d.act_mask = q.obj_mask;
               // loop select may toggle while running, so latch it with the masks
               d.act_cl = CLOSED_LOOP_SELECT_IN;
            end
         end
         ST_RUN: begin
            if (!RUN_IN) begin
               d.phase = ST_HALT;
            end
         end
         default: begin
            d.phase = ST_HALT;
         end
      endcase

      d.pos = res_pos;
      d.vel = res_vel;
      d.comm = res_comm;
      d.missing = res_pos.fallback | res_vel.fallback | res_comm.fallback;

      // object access: a mask write always lands in the stored mask, even while running
      if (OD_REQ_IN.wr) begin
         d.rsp.ack = 1'b1;
         if (OD_REQ_IN.index == IDX_SELECT && OD_REQ_IN.sub == SUB_SENSORLESS) begin
            d.obj_mask[0] = OD_REQ_IN.wdata[7:0];
         end else if (OD_REQ_IN.index == IDX_SELECT && OD_REQ_IN.sub == SUB_ENCODER) begin
            d.obj_mask[1] = OD_REQ_IN.wdata[7:0];
         end else begin
            // read-only and unknown entries refuse writes
            d.rsp.err = 1'b1;
         end
      end else if (OD_REQ_IN.rd) begin
         d.rsp.ack = 1'b1;
         if (OD_REQ_IN.index == IDX_SELECT) begin
            case (OD_REQ_IN.sub)
               SUB_COUNT: d.rsp.rdata = {8'h00, SELECT_COUNT_RESET};
               SUB_SENSORLESS: d.rsp.rdata = {8'h00, q.obj_mask[0]};
               SUB_ENCODER: d.rsp.rdata = {8'h00, q.obj_mask[1]};
               default: d.rsp.err = 1'b1;
            endcase
         end else if (OD_REQ_IN.index == IDX_MAP) begin
            case (OD_REQ_IN.sub)
               SUB_COUNT: d.rsp.rdata = {8'h00, MAP_COUNT_RESET};
               SUB_SENSORLESS: d.rsp.rdata = CFG_INDEX_SENSORLESS;
               SUB_ENCODER: d.rsp.rdata = CFG_INDEX_ENCODER;
               default: d.rsp.err = 1'b1;
            endcase
         end else begin
            d.rsp.err = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         q.phase <= ST_HALT;
         q.obj_mask <= {MASK_RESET, MASK_RESET};
         q.act_mask <= {MASK_RESET, MASK_RESET};
         q.act_cl <= 1'b0;
         q.pos <= '0;
         q.vel <= '0;
         q.comm <= '0;
         q.missing <= 1'b0;
         q.rsp <= '0;
      end else begin
         q <= d;
      end
   end

   assign OD_RSP_OUT = q.rsp;
   assign POS_SRC_OUT = q.pos.sensor;
   assign POS_VALID_OUT = q.pos.valid;
   assign VEL_SRC_OUT = q.vel.sensor;
   assign VEL_VALID_OUT = q.vel.valid;
   assign COMM_SRC_OUT = q.comm.sensor;
   assign COMM_VALID_OUT = q.comm.valid;
   assign MISSING_OUT = q.missing;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   latch_on_entry_a: assert property (
      (q.phase == ST_HALT && RUN_IN) |=> (q.act_mask == $past(q.obj_mask))
   ) else $error("active masks not taken on run entry");

   hold_while_run_a: assert property (
      (q.phase == ST_RUN && RUN_IN) |=> (q.phase == ST_RUN && $stable(q.act_mask))
   ) else $error("active masks moved while running");

   count_read_a: assert property (
      (OD_REQ_IN.rd && !OD_REQ_IN.wr && OD_REQ_IN.index == IDX_SELECT
         && OD_REQ_IN.sub == SUB_COUNT)
      |=> (OD_RSP_OUT.ack && !OD_RSP_OUT.err && OD_RSP_OUT.rdata == 16'h0002)
   ) else $error("selection count read wrong");

   mask_store_a: assert property (
      (OD_REQ_IN.wr && OD_REQ_IN.index == IDX_SELECT && OD_REQ_IN.sub == SUB_ENCODER)
      |=> (q.obj_mask[1] == $past(OD_REQ_IN.wdata[7:0]) && OD_RSP_OUT.ack)
   ) else $error("encoder mask write not stored");

   encoder_first_a: assert property (
      q.act_mask[1][BIT_POS] |=> (POS_SRC_OUT == SENSOR_ENCODER && POS_VALID_OUT)
   ) else $error("encoder not preferred for position");

   fallback_pick_a: assert property (
      (!q.act_mask[1][BIT_VEL] && q.act_mask[0][BIT_VEL])
      |=> (VEL_SRC_OUT == SENSOR_SENSORLESS && VEL_VALID_OUT && MISSING_OUT)
   ) else $error("velocity fallback wrong");

   comm_ignored_a: assert property (
      (!q.act_cl) |=> (!COMM_VALID_OUT && COMM_SRC_OUT == SENSOR_NONE)
   ) else $error("commutation used in open loop");

   open_loop_vel_a: assert property (
      (!q.act_cl && q.act_mask[1][BIT_VEL]) |=> (VEL_SRC_OUT == SENSOR_ENCODER)
   ) else $error("velocity source lost in open loop");

   map_read_a: assert property (
      (OD_REQ_IN.rd && !OD_REQ_IN.wr && OD_REQ_IN.index == IDX_MAP
         && OD_REQ_IN.sub == SUB_ENCODER)
      |=> (OD_RSP_OUT.rdata == 16'h33A0 && !OD_RSP_OUT.err)
   ) else $error("encoder map entry wrong");

   none_flag_a: assert property (
      (!q.act_mask[1][BIT_POS] && !q.act_mask[0][BIT_POS])
      |=> (MISSING_OUT && !POS_VALID_OUT)
   ) else $error("unassigned role not flagged");

   map_count_a: assert property (
      (OD_REQ_IN.rd && !OD_REQ_IN.wr && OD_REQ_IN.index == IDX_MAP
         && OD_REQ_IN.sub == SUB_COUNT)
      |=> (OD_RSP_OUT.ack && !OD_RSP_OUT.err && OD_RSP_OUT.rdata == 16'h0002)
   ) else $error("map count read wrong");

   ro_refuse_a: assert property (
      (OD_REQ_IN.wr && OD_REQ_IN.index == IDX_MAP)
      |=> (OD_RSP_OUT.ack && OD_RSP_OUT.err && $stable(q.obj_mask))
   ) else $error("write to mapping table not refused");

   sensorless_map_a: assert property (
      (OD_REQ_IN.rd && !OD_REQ_IN.wr && OD_REQ_IN.index == IDX_MAP
         && OD_REQ_IN.sub == SUB_SENSORLESS)
      |=> (OD_RSP_OUT.rdata == 16'h3380 && !OD_RSP_OUT.err)
   ) else $error("sensorless map entry wrong");

   comm_closed_a: assert property (
      (q.act_cl && q.act_mask[1][BIT_COMM])
      |=> (COMM_SRC_OUT == SENSOR_ENCODER && COMM_VALID_OUT)
   ) else $error("commutation source wrong in closed loop");

   cl_hold_a: assert property (
      (q.phase == ST_RUN && RUN_IN) |=> $stable(q.act_cl)
   ) else $error("loop mode moved while running");

   run_exit_a: assert property (
      (q.phase == ST_RUN && !RUN_IN) |=> (q.phase == ST_HALT)
   ) else $error("run exit not seen");

   vel_encoder_a: assert property (
      q.act_mask[1][BIT_VEL] |=> (VEL_SRC_OUT == SENSOR_ENCODER && VEL_VALID_OUT)
   ) else $error("encoder not preferred for velocity");

endmodule // feedback_source_select

// ===== sim/od_master.sv
// Purpose: fieldbus master model issuing object dictionary requests
// Assumes: requests change at the falling edge, one per cycle
// Notes: idle cycles keep the qualifiers low and show a fresh $urandom pattern on index, sub and data, which may repeat the last value
`timescale 1ns/1ps
module od_master (
   input wire logic clk_in,
   output fbsel_pkg::od_req_type req_out
);
   import fbsel_pkg::*;

   initial req_out = '0;

   // caller ends a burst with an idle request; back to back calls overwrite once per edge
   task automatic xfer(input od_req_type r);
      @(negedge clk_in);
      if (!r.rd && !r.wr) begin
         r[39:0] = 40'({$urandom, $urandom});
      end
      req_out = r;
      @(posedge clk_in);
   endtask
endmodule // od_master

// ===== sim/tb_top.sv
// Purpose: self-checking bench for the feedback source selector
// Assumes: inputs change at the falling edge of the clock
// Notes: object responses are checked against a queue of notes in arrival order
`timescale 1ns/1ps
module tb_top;
   import fbsel_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b0;
   logic cl = 1'b0;
   od_req_type req;
   od_rsp_type rsp;
   logic [1:0] ps, vs, cs;
   logic pv, vv, cv, miss;
   int errors = 0;
   int cmp_count = 0;
   logic [17:0] exp_q[$];
   logic [17:0] note;
   logic [7:0] sl, en;
   logic [15:0] rv [6] = '{16'h0002, 16'h0000, 16'h0000, 16'h0002, 16'h3380, 16'h33A0};

   always #12.5 clk = ~clk;

   od_master i_od_master (.clk_in(clk), .req_out(req));
   feedback_source_select i_feedback_source_select (.CLK_IN(clk), .RST_IN(rst), .RUN_IN(run),
      .CLOSED_LOOP_SELECT_IN(cl), .OD_REQ_IN(req), .OD_RSP_OUT(rsp), .POS_SRC_OUT(ps),
      .POS_VALID_OUT(pv), .VEL_SRC_OUT(vs), .VEL_VALID_OUT(vv), .COMM_SRC_OUT(cs),
      .COMM_VALID_OUT(cv), .MISSING_OUT(miss));

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (e !== s) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask

   // note {check data, err, rdata}; write responses carry no data to compare
   task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [15:0] wd, input logic e, input logic [15:0] rd);
      exp_q.push_back({~w, e, rd});
      i_od_master.xfer({~w, w, idx, sub, wd});
   endtask

   always @(negedge clk) begin
      if (rsp.ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected ack", 0, 1);
         end else begin
            note = exp_q.pop_front();
            check("err", note[16], rsp.err);
            if (note[17]) check("rdata", note[15:0], rsp.rdata);
         end
      end
   end

   function automatic logic [2:0] pick(input logic e, input logic s);
      return e ? {1'b1, SENSOR_ENCODER} : (s ? {1'b1, SENSOR_SENSORLESS} : 3'h0);
   endfunction

   task automatic chk_roles(input logic [7:0] s1, input logic [7:0] s2, input logic c);
      check("pos", pick(s2[BIT_POS], s1[BIT_POS]), {pv, ps});
      check("vel", pick(s2[BIT_VEL], s1[BIT_VEL]), {vv, vs});
      check("comm", c ? pick(s2[BIT_COMM], s1[BIT_COMM]) : 3'h0, {cv, cs});
      check("missing", !s2[BIT_POS] || !s2[BIT_VEL] || (c && !s2[BIT_COMM]), miss);
   endtask

   // run must be low one cycle to re-arm entry; outputs settle two edges after entry
   task automatic enter(input logic c);
      @(negedge clk);
      run <= 1'b0;
      @(negedge clk);
      run <= 1'b1;
      cl <= c;
      repeat (3) @(negedge clk);
   endtask

   task automatic end_of_test();
      check("pending notes", 0, exp_q.size());
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #50000;
      errors++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hA49A8D25));
      repeat (5) @(negedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      chk_roles(8'h00, 8'h00, 1'b0);
      for (int i = 0; i < 6; i++) begin
         acc(0, i < 3 ? IDX_SELECT : IDX_MAP, 8'(i % 3), 16'h0000, 0, rv[i]);
      end
      acc(1, IDX_MAP, SUB_SENSORLESS, 16'h1234, 1, 16'h0000);
      acc(1, IDX_SELECT, SUB_COUNT, 16'h0005, 1, 16'h0000);
      acc(0, 16'h3205, SUB_COUNT, 16'h0000, 1, 16'h0000);
      acc(0, IDX_SELECT, 8'h03, 16'h0000, 1, 16'h0000);
      acc(0, IDX_MAP, SUB_SENSORLESS, 16'h0000, 0, 16'h3380);
      acc(0, IDX_SELECT, SUB_COUNT, 16'h0000, 0, 16'h0002);
      for (int k = 0; k < 12; k++) begin
         sl = 8'($urandom);
         en = (k == 0) ? 8'h00 : 8'($urandom);
         acc(1, IDX_SELECT, SUB_SENSORLESS, {8'($urandom), sl}, 0, 16'h0000);
         acc(1, IDX_SELECT, SUB_ENCODER, {8'($urandom), en}, 0, 16'h0000);
         acc(0, IDX_SELECT, SUB_ENCODER, 16'h0000, 0, {8'h00, en});
         i_od_master.xfer('0);
         enter(k[0]);
         chk_roles(sl, en, k[0]);
         acc(1, IDX_SELECT, SUB_SENSORLESS, {8'h00, ~sl}, 0, 16'h0000);
         acc(1, IDX_SELECT, SUB_ENCODER, {8'h00, ~en}, 0, 16'h0000);
         acc(0, IDX_SELECT, SUB_SENSORLESS, 16'h0000, 0, {8'h00, ~sl});
         i_od_master.xfer('0);
         @(negedge clk);
         cl <= ~k[0];
         repeat (3) @(negedge clk);
         chk_roles(sl, en, k[0]);
         enter(k[1]);
         chk_roles(~sl, ~en, k[1]);
      end
      repeat (3) @(negedge clk);
      end_of_test();
   end
endmodule // tb_top
